// ### fpp_params.svh
`ifndef FPP_PARAMS_SVH
`define FPP_PARAMS_SVH
`define FPP_DATA_W 8
`define FPP_LATCH_RESET 8'h00
`define FPP_COL_LSB 0
`define FPP_COL_W 3
`define FPP_DISP_LSB 2
`define FPP_DISP_W 6
`define FPP_ROW_LSB 4
`define FPP_ROW_W 4
`define FPP_SELFTEST_BIT 0
`define FPP_CALEN_BIT 1
`define FPP_FIXED_ONE_BIT 2
`define FPP_FIXED_ZERO_BIT 3
`define FPP_COLS 8
`endif

// ### fpp_pkg.sv
package fpp_pkg;
  typedef logic [7:0] fpp_byte_t;
  typedef enum logic {fpp_sel_idle, fpp_sel_active} fpp_sel_t;
endpackage

// ### fpp_col_decoder.sv
`timescale 1ns/1ps
`include "fpp_params.svh"
module fpp_col_decoder #(
  parameter int SEL_W = 3,
  parameter int COLS = 8
) (
  input wire logic [SEL_W-1:0] sel_i,
  output logic [COLS-1:0] col_n_o
);
  always_comb begin
    col_n_o = '1;
    col_n_o[sel_i] = 1'b0;
  end
endmodule

// ### fpp_front_panel_port.sv
`timescale 1ns/1ps
`include "fpp_params.svh"
module fpp_front_panel_port #(
  parameter int DATA_W = `FPP_DATA_W,
  parameter int ROWS = `FPP_ROW_W,
  parameter int COLS = `FPP_COLS
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_clear_n_i,
  input wire logic drive_latch_select_n_i,
  input wire logic sense_port_select_n_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic [DATA_W-1:0] data_oe_n_o,
  output logic [`FPP_DISP_W-1:0] display_o,
  output logic [COLS-1:0] keypad_col_n_o,
  input wire logic [ROWS-1:0] keypad_row_n_i,
  input wire logic option_jumper_skip_test_i,
  input wire logic option_jumper_cal_lock_i
);
  localparam fpp_pkg::fpp_byte_t LATCH_RST = `FPP_LATCH_RESET;

  fpp_pkg::fpp_sel_t wr_sel, next_wr_sel;
  logic load_strobe;
  logic clear_now;
  fpp_pkg::fpp_byte_t latch, next_latch;
  logic [`FPP_DISP_W-1:0] disp_q, next_disp_q;
  logic [COLS-1:0] cols_n;
  logic [COLS-1:0] col_q, next_col_q;
  logic sense_on;
  logic [ROWS-1:0] row_level;
  logic self_test_req;
  logic cal_enable;
  logic [DATA_W-1:0] sense_word;
  wire [DATA_W-1:0] rd_data;
  wire [DATA_W-1:0] oe_n;

  // Select seen one cycle late, so edge is detected on its release
  always_comb begin
    next_wr_sel = fpp_pkg::fpp_sel_idle;
    if (!drive_latch_select_n_i) begin
      next_wr_sel = fpp_pkg::fpp_sel_active;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_sel <= fpp_pkg::fpp_sel_idle;
    end else begin
      wr_sel <= next_wr_sel;
    end
  end

  always_comb begin
    load_strobe = 1'b0;
    clear_now = !power_clear_n_i;
    unique case (wr_sel)
      fpp_pkg::fpp_sel_idle: begin
        load_strobe = 1'b0;
      end
      fpp_pkg::fpp_sel_active: begin
        load_strobe = drive_latch_select_n_i;
      end
    endcase
    next_latch = latch;
    if (load_strobe) begin
      next_latch = data_i;
    end
    if (clear_now) begin
      next_latch = `FPP_LATCH_RESET;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      latch <= `FPP_LATCH_RESET;
    end else begin
      latch <= next_latch;
    end
  end

  // Own flops so the display pins never see the decoder's lag
  always_comb begin
    next_disp_q = next_latch[`FPP_DISP_LSB +: `FPP_DISP_W];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      disp_q <= LATCH_RST[`FPP_DISP_LSB +: `FPP_DISP_W];
    end else begin
      disp_q <= next_disp_q;
    end
  end

  fpp_col_decoder #(
    .SEL_W(`FPP_COL_W),
    .COLS(COLS)
  ) u_keypad_column_decoder (
    .sel_i(latch[`FPP_COL_LSB +: `FPP_COL_W]),
    .col_n_o(cols_n)
  );

  // Registered so outputs come straight from flops; one cycle extra lag
  always_comb begin
    next_col_q = cols_n;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      col_q <= {{(COLS-1){1'b1}}, 1'b0};
    end else begin
      col_q <= next_col_q;
    end
  end

  always_comb begin
    sense_on = !sense_port_select_n_i;
    row_level = keypad_row_n_i;
    self_test_req = !option_jumper_skip_test_i;
    cal_enable = !option_jumper_cal_lock_i;
    sense_word = '0;
    sense_word[`FPP_ROW_LSB +: `FPP_ROW_W] = row_level;
    sense_word[`FPP_SELFTEST_BIT] = self_test_req;
    sense_word[`FPP_CALEN_BIT] = cal_enable;
    sense_word[`FPP_FIXED_ONE_BIT] = 1'b1;
    sense_word[`FPP_FIXED_ZERO_BIT] = 1'b0;
  end

  // One data and one enable flop per bus lane
  for (genvar lane = 0; lane < DATA_W; lane++) begin : g_lane
    logic lane_d, next_lane_d;
    logic lane_oe_n, next_lane_oe_n;

    always_comb begin
      next_lane_d = sense_word[lane];
      next_lane_oe_n = !sense_on;
    end

    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        lane_d <= 1'b0;
        lane_oe_n <= 1'b1;
      end else begin
        lane_d <= next_lane_d;
        lane_oe_n <= next_lane_oe_n;
      end
    end

    assign rd_data[lane] = lane_d;
    assign oe_n[lane] = lane_oe_n;
  end

  assign data_o = rd_data;
  assign data_oe_n_o = oe_n;
  assign display_o = disp_q;
  assign keypad_col_n_o = col_q;
endmodule

// ### fpp_keypad_model.sv
`timescale 1ns/1ps
module fpp_keypad_model (
  input wire logic [7:0] col_n_i,
  input wire logic [5:0] key_i,
  output logic [3:0] row_n_o
);
  assign row_n_o = ~({3'h0, key_i[5] & ~col_n_i[key_i[4:2]]} << key_i[1:0]);
endmodule

// ### fpp_properties.sv
`timescale 1ns/1ps
module fpp_properties (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_clear_n_i,
  input wire logic drive_latch_select_n_i,
  input wire logic sense_port_select_n_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic [7:0] data_oe_n_o,
  input wire logic [5:0] display_o,
  input wire logic [7:0] keypad_col_n_o,
  input wire logic [3:0] keypad_row_n_i,
  input wire logic option_jumper_skip_test_i,
  input wire logic option_jumper_cal_lock_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire rd = !sense_port_select_n_i;
  wire ws = drive_latch_select_n_i;
  wire pc = power_clear_n_i;
  sequence wr_s; $rose(ws) && pc; endsequence
  en_a: assert property (rd |=> !data_oe_n_o) else $error("oe");
  off_a: assert property (!rd |=> &data_oe_n_o) else $error("oe");
  fix_a: assert property (rd |=> data_o[3:2] == 2'h1) else $error("d");
  row_nibble_a: assert property (rd |=>
    data_o[7:4] == $past(keypad_row_n_i)) else $error("rows");
  jumper_bits_a: assert property (rd |=>
    data_o[1:0] == ~$past({option_jumper_cal_lock_i,
    option_jumper_skip_test_i})) else $error("jumpers");
  one_a: assert property ($onehot(~keypad_col_n_o)) else $error("c");
  clr_a: assert property (!pc |=> !display_o) else $error("clr");
  hold_a: assert property ($stable(ws) && pc |=> $stable(display_o))
    else $error("hold");
  disp_a: assert property (wr_s |=> display_o == $past(data_i[7:2]))
    else $error("disp");
  col_a: assert property (wr_s |=> ##1
    keypad_col_n_o == ~(8'h01 << $past(data_i[2:0], 2))) else $error("col");
endmodule

// ### fpp_front_panel_port_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
module fpp_front_panel_port_tb;
  logic clock_i = 1'h0, rst_i = 1'h1, power_clear_n_i = 1'h1;
  logic drive_latch_select_n_i = 1'h1, sense_port_select_n_i = 1'h1;
  logic option_jumper_skip_test_i = 1'h0, option_jumper_cal_lock_i = 1'h0;
  logic [7:0] data_i = 8'h00, data_o, data_oe_n_o, keypad_col_n_o;
  logic [5:0] display_o, key = 6'h2e;
  logic [3:0] keypad_row_n_i;
  int failures = 0, n_compared = 0, cyc = 0;
  fpp_front_panel_port uut (.*);
  fpp_keypad_model kp (.col_n_i(keypad_col_n_o), .key_i(key),
    .row_n_o(keypad_row_n_i));
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 1000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] w);
    @(posedge clock_i) #1 drive_latch_select_n_i = 1'h0;
    data_i = w;
    @(posedge clock_i) #1 drive_latch_select_n_i = 1'h1;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  task automatic t_scan;
    for (int c = 0; c < 8; c++) begin
      {option_jumper_cal_lock_i, option_jumper_skip_test_i} = 2'(c);
      wr(8'(8'h25 * c));
      `CHK(display_o, 6'(8'h25 * c >> 2))
      `CHK(keypad_col_n_o, ~(8'h01 << 3'(5 * c)))
      sense_port_select_n_i = 1'h0;
      repeat (2) @(posedge clock_i);
      // Key sits on column three, row two
      #1 `CHK(data_o[7:4], (c == 7) ? 4'hb : 4'hf)
      `CHK(data_o[3:0], {2'h1, ~c[1], ~c[0]})
      `CHK(data_oe_n_o, 8'h00)
      sense_port_select_n_i = 1'h1;
      repeat (2) @(posedge clock_i);
      #1 `CHK(data_oe_n_o, 8'hff)
    end
  endtask
  task automatic t_rst;
    wr(8'hff);
    sense_port_select_n_i = 1'h0;
    @(posedge clock_i) #1 rst_i = 1'h1;
    @(posedge clock_i);
    #1 `CHK({display_o, keypad_col_n_o}, 14'h00fe)
    `CHK({data_o, data_oe_n_o}, 16'h00ff)
    rst_i = 1'h0;
    repeat (2) @(posedge clock_i);
    #1 `CHK(data_oe_n_o, 8'h00)
    sense_port_select_n_i = 1'h1;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic t_refresh;
    for (int t = 0; t < 3; t++) begin
      repeat (16) @(posedge clock_i);
      wr(8'hb4);
      `CHK(display_o, 6'h2d)
      `CHK(keypad_col_n_o, 8'hef)
    end
  endtask
  task automatic t_clr;
    wr(8'hff);
    power_clear_n_i = 1'h0;
    wr(8'h5c);
    `CHK({display_o, keypad_col_n_o}, 14'h00fe)
    power_clear_n_i = 1'h1;
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    #1 rst_i = 1'h0;
    t_scan();
    t_rst();
    t_refresh();
    t_clr();
    stop_test();
  end
endmodule
bind fpp_front_panel_port fpp_properties chk (.*);
